// >>> hdl/pwp_pkg.sv
// constants shared by the peripheral write protect controller
// assumes a 32-bit register bus with byte strobes and one clock domain
package pwp_pkg;

   // register byte offsets
   localparam logic [7:0]  OFS_CLEAR_VIEW = 8'h00;
   localparam logic [7:0]  OFS_SET_VIEW   = 8'h04;

   // bit positions of the guarded peripherals in the first instance
   localparam int          BIT_EXT_IRQ_CTRL   = 6;
   localparam int          BIT_REAL_TIME_CNT  = 5;
   localparam int          BIT_WATCHDOG_TIMER = 4;
   localparam int          BIT_CLOCK_GENERATOR = 3;
   localparam int          BIT_SYSTEM_CONTROL = 2;
   localparam int          BIT_POWER_MANAGER  = 1;

   // reset value and implemented bits of the first instance
   localparam logic [31:0] PROT_RESET_0 = 32'h0000_0000;
   localparam logic [31:0] PROT_VALID_0 = 32'h0000_007e;

   // instances below this index have their bus clock on after reset
   localparam int          CLK_ON_INSTANCES = 2;

   // register bus transfer phase
   typedef enum logic [0:0] {
      ph_idle,
      ph_access
   } phase_t;

endpackage

// >>> hdl/guard_filter.sv
// decides whether a write from the bridge may reach a peripheral
// assumes the bridge presents one peripheral index per request
`timescale 1ns/10ps
`default_nettype none
module guard_filter
   import pwp_pkg::*;
#(
   parameter int NPERIPH = 32
) (
   // protection state
   input  wire logic [NPERIPH-1:0]         prot,
   // request from the bridge
   input  wire logic                       acc_valid,
   input  wire logic                       acc_write,
   input  wire logic                       acc_debug,
   input  wire logic [$clog2(NPERIPH)-1:0] acc_periph,
   // decision back to the bridge
   output logic                            acc_allow,
   output logic                            acc_error
);

   logic hit;

   // only writes to a protected slot are stopped; debugger passes always
   assign hit       = acc_valid & acc_write & ~acc_debug & prot[acc_periph];
   assign acc_error = hit;
   assign acc_allow = acc_valid & ~hit;

endmodule
`default_nettype wire

// >>> hdl/peripheral_write_protect.sv
// peripheral write protect controller, one per bus bridge
// assumes an APB-style slave port with byte strobes, one clock, and a
// bridge that stops a peripheral write whenever acc_allow is low
`timescale 1ns/10ps
`default_nettype none
module peripheral_write_protect
   import pwp_pkg::*;
#(
   parameter int          INSTANCE    = 0,
   parameter int          NPERIPH     = 32,
   parameter logic [31:0] RESET_VALUE = PROT_RESET_0,
   parameter logic [31:0] VALID_MASK  = PROT_VALID_0
) (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_b,
   // register port
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [7:0]                 paddr,
   input  wire logic [31:0]                pwdata,
   input  wire logic [3:0]                 pstrb,
   output logic [31:0]                     prdata,
   output logic                            pready,
   output logic                            pslverr,
   // bus clock control from the power manager
   input  wire logic                       pm_clk_enable,
   input  wire logic                       pm_clk_disable,
   output logic                            guard_bus_clock,
   // peripheral write check from the bridge
   input  wire logic                       acc_valid,
   input  wire logic                       acc_write,
   input  wire logic                       acc_debug,
   input  wire logic [$clog2(NPERIPH)-1:0] acc_periph,
   output logic                            acc_allow,
   output logic                            acc_error
);

   typedef struct packed {
      phase_t      phase;
      logic [31:0] prot;
      logic [31:0] rdata;
      logic        err;
      logic        clk_on;
   } state_t;

   localparam logic  CLK_RESET = (INSTANCE < CLK_ON_INSTANCES);
   localparam state_t RESET_STATE = '{
      phase:  ph_idle,
      prot:   RESET_VALUE & VALID_MASK,
      rdata:  32'h0000_0000,
      err:    1'b0,
      clk_on: CLK_RESET
   };

   state_t      s;
   state_t      next_s;
   logic        setup;
   logic        access;
   logic        hit_set;
   logic        hit_clr;
   logic [31:0] wbits;

   // expand byte strobes into a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] strb);
      lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction

   // decode and write data shared by the setup and access phases
   assign setup   = psel & ~penable;
   assign access  = psel & penable;
   assign hit_set = (paddr == OFS_SET_VIEW);
   assign hit_clr = (paddr == OFS_CLEAR_VIEW);
   assign wbits   = pwdata & lane_mask(pstrb) & VALID_MASK;

   // next state of the whole controller
   always_comb begin
      next_s = s;
      if (pm_clk_enable) begin
         next_s.clk_on = 1'b1;
      end else if (pm_clk_disable) begin
         next_s.clk_on = 1'b0;
      end
      case (s.phase)
         ph_idle: begin
            if (setup) begin
               next_s.phase = ph_access;
               next_s.rdata = 32'h0000_0000;
               next_s.err   = 1'b0;
               if (s.clk_on && !pwrite && (hit_set || hit_clr)) begin
                  next_s.rdata = s.prot;
               end
               if (s.clk_on && pwrite && hit_set && |(wbits & s.prot)) begin
                  next_s.err = 1'b1;
               end
               if (s.clk_on && pwrite && hit_clr && |(wbits & ~s.prot)) begin
                  next_s.err = 1'b1;
               end
            end
         end
         ph_access: begin
            next_s.phase = ph_idle;
            // a refused write changes no bit at all, not even the others
            // zero bits untouched
            if (access && pwrite && s.clk_on && !s.err) begin
               if (hit_set) begin
                  next_s.prot = s.prot | wbits;
               end else if (hit_clr) begin
                  next_s.prot = s.prot & ~wbits;
               end
            end
         end
         default: begin
            next_s.phase = ph_idle;
         end
      endcase
   end

   // single state register, synchronous active low reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s <= RESET_STATE;
      end else begin
         s <= next_s;
      end
   end

   // register port answers; never stalls, so the bridge needs no timeout
   assign pready          = 1'b1;
   assign pslverr         = (s.phase == ph_access) & s.err;
   assign prdata          = s.rdata;
   assign guard_bus_clock = s.clk_on;

   // no sleep input, runs without clock
   guard_filter #(
      .NPERIPH    (NPERIPH)
   ) u_filter (
      .prot       (s.prot[NPERIPH-1:0]),
      .acc_valid  (acc_valid),
      .acc_write  (acc_write),
      .acc_debug  (acc_debug),
      .acc_periph (acc_periph),
      .acc_allow  (acc_allow),
      .acc_error  (acc_error)
   );

   // checks on the controller's own behaviour
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence wr_set_seq;
      setup && pwrite && hit_set && s.clk_on && (s.phase == ph_idle);
   endsequence

   sequence wr_clr_seq;
      setup && pwrite && hit_clr && s.clk_on && (s.phase == ph_idle);
   endsequence

   sequence ok_access_seq;
      access && !next_s.err;
   endsequence

   // the write data stands through the access phase, so its past value
   // one cycle back is the word that was committed
   property set_bits_p;
      wr_set_seq ##1 ok_access_seq |=>
      ((s.prot & $past(wbits)) == $past(wbits));
   endproperty

   property clr_bits_p;
      wr_clr_seq ##1 ok_access_seq |=>
      ((s.prot & $past(wbits)) == 32'h0);
   endproperty

   set_commit_a: assert property (set_bits_p)
      else $error("set view write did not protect");
   clear_commit_a: assert property (clr_bits_p)
      else $error("clear view write did not unprotect");
   read_views_a: assert property (
      (setup && !pwrite && (hit_set || hit_clr) && s.clk_on &&
       (s.phase == ph_idle)) |=> (prdata == $past(s.prot)))
      else $error("view readback differs from protection word");
   zero_keeps_a: assert property (
      (s.phase == ph_access) |=>
      (((s.prot ^ $past(s.prot)) & ~$past(wbits)) == 32'h0))
      else $error("unwritten protection bit changed");
   blocked_write_a: assert property (
      (acc_valid && acc_write && !acc_debug && s.prot[acc_periph]) |->
      (acc_error && !acc_allow))
      else $error("write to protected peripheral not stopped");
   double_set_a: assert property (
      (wr_set_seq and (|(wbits & s.prot))) |=>
      (pslverr ##1 (!pslverr && $stable(s.prot))))
      else $error("double protect gave no error");
   double_clr_a: assert property (
      (wr_clr_seq and (|(wbits & ~s.prot))) |=>
      (pslverr ##1 $stable(s.prot)))
      else $error("double unprotect gave no error");
   debug_pass_a: assert property (
      (acc_valid && acc_debug) |-> (acc_allow && !acc_error))
      else $error("debugger access was stopped");
   reset_clock_a: assert property (
      (!$past(rst_b) && !$past(pm_clk_enable) && !$past(pm_clk_disable)) |->
      (guard_bus_clock == CLK_RESET) && (s.prot == (RESET_VALUE & VALID_MASK)))
      else $error("reset clock or protection state wrong");
   gated_frozen_a: assert property (
      (!s.clk_on && !pm_clk_enable && (s.phase == ph_access)) |=>
      $stable(s.prot))
      else $error("protection changed while bus clock gated");

endmodule
`default_nettype wire

// >>> verification/bridge_model.sv
// bridge side model: register bus master of the write guard
// assumes one clock and a slave that answers with pready
`timescale 1ns/10ps
`default_nettype none
module bridge_model (
   // clock
   input  wire logic        clk,
   // register bus
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   // high when a transfer never saw pready
   output logic             hung
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb, hung} = '0;
   end

   // one transfer; the request stands until pready is seen at an edge
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(negedge clk);
      while (pready !== 1'b1 && n < 16) begin
         @(negedge clk);
         n++;
      end
      hung = (n == 16);
      rd  = prdata;
      err = pslverr;
      @(posedge clk);
      psel    <= 1'b0;
      penable <= 1'b0;
      // released data must not keep showing the last value
      pwdata  <= ~d;
   endtask
endmodule
`default_nettype wire

// >>> verification/peripheral_write_protect_bench.sv
// self-checking bench for the peripheral write protect controller
// assumes instance 0 defaults and the bridge model as bus master
`timescale 1ns/10ps
`default_nettype none
module peripheral_write_protect_bench import pwp_pkg::*;;
   logic        clk, rst_b, pm_clk_enable, pm_clk_disable, err;
   logic        acc_valid, acc_write, acc_debug, acc_allow, acc_error;
   logic        psel, penable, pwrite, pready, pslverr, hung;
   logic        guard_bus_clock, bus_clock_2;
   logic [4:0]  acc_periph;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, prot, slots;
   logic [3:0]  pstrb;
   int          n_fail, samples_checked;

   peripheral_write_protect i_dut (.clk(clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pm_clk_enable(pm_clk_enable), .pm_clk_disable(pm_clk_disable),
      .guard_bus_clock(guard_bus_clock), .acc_valid(acc_valid),
      .acc_write(acc_write), .acc_debug(acc_debug),
      .acc_periph(acc_periph), .acc_allow(acc_allow),
      .acc_error(acc_error));
   bridge_model i_bridge (.clk(clk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .hung(hung));
   // third bridge instance: its bus clock starts gated
   peripheral_write_protect #(.INSTANCE(2)) i_dut_gated (.clk(clk),
      .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(),
      .pready(), .pslverr(), .pm_clk_enable(pm_clk_enable),
      .pm_clk_disable(pm_clk_disable), .guard_bus_clock(bus_clock_2),
      .acc_valid(acc_valid), .acc_write(acc_write), .acc_debug(acc_debug),
      .acc_periph(acc_periph), .acc_allow(), .acc_error());

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic give_verdict();
      if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // a hung bus ends the run at once
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      i_bridge.xfer(w, a, d, s, rd, err);
      if (hung) begin
         n_fail++;
         give_verdict();
      end
   endtask

   task automatic rdchk(input logic [7:0] a);
      bus(1'b0, a, 32'h0000_0000, 4'hf);
      chk("read_view", rd, prot);
   endtask

   // model of one strobed write; unstrobed lanes count as zeros
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      logic [31:0] m, hit;
      logic        e;
      m = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & PROT_VALID_0;
      hit = (a == OFS_SET_VIEW) ? (m & prot) : (m & ~prot);
      e = (a <= OFS_SET_VIEW) && (hit != 0);
      bus(1'b1, a, d, s);
      if (!e && a == OFS_SET_VIEW) prot = prot | m;
      if (!e && a == OFS_CLEAR_VIEW) prot = prot & ~m;
      chk("write_error", {31'h0, err}, {31'h0, e});
      rdchk(OFS_CLEAR_VIEW);
      rdchk(OFS_SET_VIEW);
   endtask

   // bridge request check, answered in the same cycle
   task automatic acc_chk(input logic w, dbg, input logic [4:0] p);
      logic blk;
      @(posedge clk);
      acc_valid  <= 1'b1;
      acc_write  <= w;
      acc_debug  <= dbg;
      acc_periph <= p;
      @(negedge clk);
      blk = w && !dbg && prot[p];
      chk("acc_error", {31'h0, acc_error}, {31'h0, blk});
      chk("acc_allow", {31'h0, acc_allow}, {31'h0, !blk});
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // bounded run: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      give_verdict();
   end

   initial begin
      {rst_b, pm_clk_enable, pm_clk_disable} = '0;
      {acc_valid, acc_write, acc_debug, acc_periph} = '0;
      prot = PROT_RESET_0 & PROT_VALID_0;
      void'($urandom(32'hd5962805));
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      chk("bus_clock", {31'h0, guard_bus_clock}, 32'h0000_0001);
      chk("gated_clock", {31'h0, bus_clock_2}, 32'h0000_0000);
      rdchk(OFS_CLEAR_VIEW);
      // protect and unprotect every guarded slot, each twice
      for (int b = 1; b < 7; b++) begin
         wr(OFS_SET_VIEW, 32'h1 << b, 4'h1 | 4'($urandom));
         wr(OFS_SET_VIEW, 32'h1 << b, 4'h1);
         acc_chk(1'b1, 1'b0, 5'(b));
         acc_chk(1'b1, 1'b1, 5'(b));
         acc_chk(1'b0, 1'b0, 5'(b));
         rdchk(OFS_SET_VIEW);
         wr(OFS_CLEAR_VIEW, 32'h1 << b, 4'h1);
         wr(OFS_CLEAR_VIEW, 32'h1 << b, 4'h1);
      end
      wr(OFS_SET_VIEW, 32'h0000_0000, 4'hf);
      wr(OFS_SET_VIEW, 32'h0000_007e, 4'he);
      // random lanes, bits and views, mixed with bridge checks
      repeat (40) begin
         wr($urandom % 2 ? OFS_SET_VIEW : OFS_CLEAR_VIEW,
            32'h1 << ($urandom % 8), 4'($urandom));
         acc_chk(1'($urandom), 1'($urandom), 5'($urandom));
      end
      bus(1'b1, 8'h08, 32'hffff_ffff, 4'hf);
      chk("unmapped_err", {31'h0, err}, 32'h0000_0000);
      bus(1'b0, 8'h08, 32'h0000_0000, 4'hf);
      chk("unmapped_read", rd, 32'h0000_0000);
      // gate the bus clock: reads give zero and writes are ignored
      pm_clk_disable <= 1'b1;
      @(posedge clk);
      pm_clk_disable <= 1'b0;
      @(negedge clk);
      chk("bus_clock", {31'h0, guard_bus_clock}, 32'h0000_0000);
      bus(1'b1, OFS_SET_VIEW, ~prot, 4'hf);
      chk("gated_err", {31'h0, err}, 32'h0000_0000);
      bus(1'b0, OFS_SET_VIEW, 32'h0000_0000, 4'hf);
      chk("gated_read", rd, 32'h0000_0000);
      pm_clk_enable <= 1'b1;
      @(posedge clk);
      pm_clk_enable <= 1'b0;
      // the gated write must have left every slot as it was
      rdchk(OFS_SET_VIEW);
      // fill every guarded slot, then a second reset in mid-run clears them
      slots = (32'h1 << BIT_EXT_IRQ_CTRL) | (32'h1 << BIT_REAL_TIME_CNT) |
              (32'h1 << BIT_WATCHDOG_TIMER) | (32'h1 << BIT_CLOCK_GENERATOR) |
              (32'h1 << BIT_SYSTEM_CONTROL) | (32'h1 << BIT_POWER_MANAGER);
      wr(OFS_SET_VIEW, ~prot, 4'hf);
      chk("guarded_slots", prot, slots);
      rst_b <= 1'b0;
      @(posedge clk);
      rst_b <= 1'b1;
      prot = PROT_RESET_0 & PROT_VALID_0;
      @(negedge clk);
      chk("bus_clock", {31'h0, guard_bus_clock}, 32'h0000_0001);
      chk("gated_clock", {31'h0, bus_clock_2}, 32'h0000_0000);
      rdchk(OFS_SET_VIEW);
      acc_chk(1'b1, 1'b0, 5'(BIT_WATCHDOG_TIMER));
      give_verdict();
   end
endmodule
`default_nettype wire
